// File: hdl/atw_pkg.sv
// constants, field layout and helper functions for the analog trim and watchdog window block
package atw_pkg;

  // ************************************************************
  // register offsets on the internal serial port
  // ************************************************************
  localparam logic [6:0] ATW_ADDR_TEST = 7'h0E;
  localparam logic [6:0] ATW_ADDR_TRIM1 = 7'h0F;
  localparam logic [6:0] ATW_ADDR_TRIM2 = 7'h10;
  localparam logic [6:0] ATW_ADDR_TRIM3 = 7'h11;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ATW_DELAY_LSB = 6;
  localparam int ATW_RSVD_LSB = 4;
  localparam int ATW_ITRIM_LSB = 0;
  localparam int ATW_B12_LOW_LSB = 6;
  localparam int ATW_B34_HIGH_LSB = 3;
  localparam int ATW_B12_HIGH_LSB = 0;
  localparam int ATW_B34_LOW_LSB = 6;
  localparam int ATW_HS23_LSB = 3;
  localparam int ATW_HS1_LSB = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0] ATW_DELAY_RST = 2'h0;
  localparam logic [3:0] ATW_ITRIM_RST = 4'h0;
  localparam logic [7:0] ATW_TRIM_RST = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam logic [2:0] ATW_LAST_BIT = 3'h7;
  localparam int ATW_CLOCK_MHZ = 125;
  // nominal longest period (select 00), microseconds
  localparam int ATW_WD_BASE_PERIOD_US = 80000;
  localparam logic [23:0] ATW_WD_BASE_CYC = 24'(ATW_WD_BASE_PERIOD_US * ATW_CLOCK_MHZ);

  typedef enum logic [1:0] {
    ATW_SPI_IDLE = 2'b00,
    ATW_SPI_ADDR = 2'b01,
    ATW_SPI_DATA = 2'b10,
    ATW_SPI_DONE = 2'b11
  } atw_spi_state_t;

  // each step of the select halves the period
  function automatic logic [23:0] atw_wd_period(input logic [23:0] base, input logic [1:0] sel);
    return base >> sel;
  endfunction

  // the sense-path select decides which recopy code reaches a bridge pair
  function automatic logic [2:0] atw_pick_recopy(input logic sense, input logic [1:0] low_code,
                                                 input logic [2:0] high_code);
    return sense ? high_code : {1'b0, low_code};
  endfunction

endpackage

// File: hdl/atw_wd_window.sv
// window watchdog: open window is the latter half of the selected period
`timescale 1ns/1ps
module atw_wd_window
  import atw_pkg::*;
#(
  parameter logic [23:0] BASE_CYC = ATW_WD_BASE_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wd_enable,
  input wire logic [1:0] wd_period_select,
  input wire logic wd_clear,
  output logic wd_window_open,
  output logic wd_timeout
);

  typedef struct packed {
    logic [23:0] cnt;
    logic open;
    logic timeout;
  } atw_wd_state_t;

  atw_wd_state_t st_reg, st_next;
  logic [23:0] period;
  logic [23:0] half;

  assign period = atw_wd_period(BASE_CYC, wd_period_select); // see RL4
  assign half = period >> 1;

  // ************************************************************
  // window sequencing
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.timeout = 1'b0;
    if (!wd_enable) begin
      st_next.cnt = 24'h000000;
      st_next.open = 1'b0;
    end else if (wd_clear) begin
      // a clear in the closed half is a window violation
      st_next.timeout = !st_reg.open; // see RL1
      st_next.cnt = 24'h000000;
      st_next.open = 1'b0;
    end else if (st_reg.cnt >= period - 24'h000001) begin
      st_next.timeout = 1'b1; // see RL4
      st_next.cnt = 24'h000000;
      st_next.open = 1'b0;
    end else begin
      st_next.cnt = st_reg.cnt + 24'h000001;
      st_next.open = (st_next.cnt >= half); // see RL1
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wd_window_open = st_reg.open;
  assign wd_timeout = st_reg.timeout;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_closed_clear;
    wd_enable && wd_clear && !st_reg.open;
  endsequence

  chk_wd_closed_clear: assert property (@(posedge clock) disable iff (!arst_n) // see RL1
    s_closed_clear |=> wd_timeout && st_reg.cnt == 24'h000000)
    else $error("clear in closed window did not time out");

  chk_wd_open_half: assert property (@(posedge clock) disable iff (!arst_n) // see RL1
    (wd_enable && !wd_clear && $stable(wd_period_select) && st_reg.cnt + 24'h000001 == half)
      |=> wd_window_open)
    else $error("window not open at half period");

  chk_wd_period_end: assert property (@(posedge clock) disable iff (!arst_n) // see RL4
    (wd_enable && !wd_clear && st_reg.cnt == period - 24'h000001) |=> wd_timeout && !wd_window_open)
    else $error("period end did not time out");

endmodule // atw_wd_window

// File: hdl/atw_trim_top.sv
// trim register bank on the internal serial port, with the window watchdog
//
// Functional notes
// RL1: only latter half of period clears watchdog
// RL2: software bounds window from min and max periods
// RL3: software clears midway, 57 ms example
// RL4: period select halves period each step
// RL5: software restores three trim bytes after reset
// RL6: production test register is never written
// RL7: software never sets trim1 reserved bits
// RL8: overcurrent delay field is read/write
// RL9: reset selects longest overcurrent delay, code 00
// RL10: current-reference trim write-only, reset cleared
// RL11: trim register two always reads zero
// RL12: bridge12 low-sense recopy trim, two bits
// RL13: bridge34 high-sense recopy trim, three bits
// RL14: bridge12 high-sense recopy trim, three bits
// RL15: bridge34 low-sense recopy trim, two bits
// RL16: high sides 2,3 recopy trim, three bits
// RL17: high side 1 recopy trim, three bits
// RL18: trim register three always reads zero
// RL19: flash range value picks clear interval
// RL20: software services watchdog only in window
// RL21: trim1 layout delay 7:6, reserved 5:4, trim 3:0
// RL22: sense select picks low or high recopy
`timescale 1ns/1ps
module atw_trim_top
  import atw_pkg::*;
#(
  // a die's watchdog range class is carried by its base period, see RL19
  parameter logic [23:0] WD_BASE_CYC = ATW_WD_BASE_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic sense_path_select,
  input wire logic wd_enable,
  input wire logic [1:0] wd_period_select,
  input wire logic wd_clear,
  output logic wd_window_open,
  output logic wd_timeout,
  output logic [1:0] switched_supply_oc_delay,
  output logic [3:0] current_reference_trim,
  output logic [1:0] bridge12_recopy_trim_low_sense,
  output logic [2:0] bridge34_recopy_trim_high_sense,
  output logic [2:0] bridge12_recopy_trim_high_sense,
  output logic [1:0] bridge34_recopy_trim_low_sense,
  output logic [2:0] highside23_recopy_trim,
  output logic [2:0] highside1_recopy_trim,
  output logic [2:0] bridge12_recopy_applied,
  output logic [2:0] bridge34_recopy_applied
);

  typedef struct packed {
    atw_spi_state_t state;
    logic [2:0] bit_cnt;
    logic sclk_prev;
    logic [7:0] shift;
    logic [6:0] addr;
    logic wr;
    logic [7:0] rd;
    logic miso;
    logic [1:0] delay;
    logic [3:0] itrim;
    logic [7:0] trim2;
    logic [7:0] trim3;
    logic [2:0] b12_applied;
    logic [2:0] b34_applied;
  } atw_top_state_t;

  atw_top_state_t st_reg, st_next;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] in_byte;
  logic last_rise;
  logic commit;

  assign sclk_rise = spi_sclk && !st_reg.sclk_prev;
  assign sclk_fall = !spi_sclk && st_reg.sclk_prev;
  assign in_byte = {st_reg.shift[6:0], spi_mosi};
  assign last_rise = sclk_rise && st_reg.bit_cnt == ATW_LAST_BIT;
  assign commit = st_reg.state == ATW_SPI_DATA && last_rise && st_reg.wr;

  // ************************************************************
  // serial frame: address(7) + write flag, then one data byte, msb first
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.sclk_prev = spi_sclk;
    if (spi_ss_n) begin
      // deselect aborts any partial frame without touching the trims
      st_next.state = ATW_SPI_IDLE;
      st_next.bit_cnt = 3'h0;
      st_next.miso = 1'b0;
    end else begin
      if (sclk_rise) begin
        st_next.shift = in_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      end
      case (st_reg.state)
        ATW_SPI_IDLE: begin
          st_next.state = ATW_SPI_ADDR;
          st_next.bit_cnt = 3'h0;
        end
        ATW_SPI_ADDR: begin
          if (last_rise) begin
            st_next.state = ATW_SPI_DATA;
            st_next.addr = in_byte[7:1];
            st_next.wr = in_byte[0];
            // write-only fields and reserved bits read back as zero
            if (in_byte[7:1] == ATW_ADDR_TRIM1) begin
              st_next.rd = {st_reg.delay, 6'h00}; // see RL8, RL21
            end else begin
              st_next.rd = ATW_TRIM_RST; // see RL11, RL18
            end
          end
        end
        ATW_SPI_DATA: begin
          if (sclk_fall) begin
            st_next.miso = st_reg.rd[7];
            st_next.rd = {st_reg.rd[6:0], 1'b0};
          end
          if (last_rise) begin
            st_next.state = ATW_SPI_DONE;
          end
        end
        ATW_SPI_DONE: begin
          st_next.state = ATW_SPI_DONE;
        end
        default: begin
          st_next.state = ATW_SPI_IDLE;
        end
      endcase
    end

    // ************************************************************
    // register writes; the production test offset takes nothing
    // ************************************************************
    if (commit) begin
      case (st_reg.addr)
        ATW_ADDR_TRIM1: begin
          // reserved bits are not stored, so they stay clear
          st_next.delay = in_byte[ATW_DELAY_LSB +: 2]; // see RL8, RL21
          st_next.itrim = in_byte[ATW_ITRIM_LSB +: 4]; // see RL10, RL21
        end
        ATW_ADDR_TRIM2: begin
          st_next.trim2 = in_byte; // see RL12, RL13, RL14
        end
        ATW_ADDR_TRIM3: begin
          st_next.trim3 = in_byte; // see RL15, RL16, RL17
        end
        default: begin
          st_next.trim2 = st_reg.trim2;
        end
      endcase
    end

    // applied codes lag the select and the stored trims by one clock
    st_next.b12_applied = atw_pick_recopy(sense_path_select, // see RL22
      st_reg.trim2[ATW_B12_LOW_LSB +: 2], st_reg.trim2[ATW_B12_HIGH_LSB +: 3]);
    st_next.b34_applied = atw_pick_recopy(sense_path_select, // see RL22
      st_reg.trim3[ATW_B34_LOW_LSB +: 2], st_reg.trim2[ATW_B34_HIGH_LSB +: 3]);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.state <= ATW_SPI_IDLE;
      st_reg.delay <= ATW_DELAY_RST; // see RL9
      st_reg.itrim <= ATW_ITRIM_RST; // see RL10
      st_reg.trim2 <= ATW_TRIM_RST; // see RL11
      st_reg.trim3 <= ATW_TRIM_RST; // see RL18
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign spi_miso = st_reg.miso;
  assign switched_supply_oc_delay = st_reg.delay;
  assign current_reference_trim = st_reg.itrim;
  assign bridge12_recopy_trim_low_sense = st_reg.trim2[ATW_B12_LOW_LSB +: 2];
  assign bridge34_recopy_trim_high_sense = st_reg.trim2[ATW_B34_HIGH_LSB +: 3];
  assign bridge12_recopy_trim_high_sense = st_reg.trim2[ATW_B12_HIGH_LSB +: 3];
  assign bridge34_recopy_trim_low_sense = st_reg.trim3[ATW_B34_LOW_LSB +: 2];
  assign highside23_recopy_trim = st_reg.trim3[ATW_HS23_LSB +: 3];
  assign highside1_recopy_trim = st_reg.trim3[ATW_HS1_LSB +: 3];
  assign bridge12_recopy_applied = st_reg.b12_applied;
  assign bridge34_recopy_applied = st_reg.b34_applied;

  atw_wd_window #(
    .BASE_CYC(WD_BASE_CYC)
  ) u_wd (
    .clock(clock),
    .arst_n(arst_n),
    .wd_enable(wd_enable),
    .wd_period_select(wd_period_select),
    .wd_clear(wd_clear),
    .wd_window_open(wd_window_open),
    .wd_timeout(wd_timeout)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_write_at(logic [6:0] a);
    commit && st_reg.addr == a;
  endsequence

  sequence s_addr_done;
    st_reg.state == ATW_SPI_ADDR && last_rise && !spi_ss_n;
  endsequence

  chk_delay_write: assert property ( // see RL8
    s_write_at(ATW_ADDR_TRIM1) |=> switched_supply_oc_delay == $past(in_byte[7:6]))
    else $error("overcurrent delay not stored");

  chk_itrim_write: assert property ( // see RL10
    s_write_at(ATW_ADDR_TRIM1) |=> current_reference_trim == $past(in_byte[3:0]))
    else $error("reference trim not stored");

  chk_trim2_write: assert property ( // see RL12
    s_write_at(ATW_ADDR_TRIM2) |=> {bridge12_recopy_trim_low_sense,
      bridge34_recopy_trim_high_sense, bridge12_recopy_trim_high_sense} == $past(in_byte))
    else $error("trim two not stored");

  chk_trim3_write: assert property ( // see RL16
    s_write_at(ATW_ADDR_TRIM3) |=> {bridge34_recopy_trim_low_sense,
      highside23_recopy_trim, highside1_recopy_trim} == $past(in_byte))
    else $error("trim three not stored");

  chk_delay_hold: assert property ( // see RL8
    !commit |=> $stable(switched_supply_oc_delay))
    else $error("overcurrent delay changed without write");

  chk_trim1_readback: assert property ( // see RL21
    (s_addr_done ##0 (in_byte[7:1] == ATW_ADDR_TRIM1)) |=> st_reg.rd == {$past(st_reg.delay), 6'h00})
    else $error("trim one read value wrong");

  chk_trim23_read_zero: assert property ( // see RL11
    (st_reg.state != ATW_SPI_IDLE && st_reg.addr != ATW_ADDR_TRIM1 && st_reg.state != ATW_SPI_ADDR)
      |-> st_reg.rd == 8'h00)
    else $error("trim two or three read not zero");

  chk_sense_apply: assert property ( // see RL22
    ($past(sense_path_select) && $stable(st_reg.trim2))
      |-> bridge12_recopy_applied == bridge12_recopy_trim_high_sense)
    else $error("high sense code not applied");

endmodule // atw_trim_top

// File: verif/atw_spi_master.sv
// serial port master model standing in for the embedded controller
`timescale 1ns/1ps
module atw_spi_master
  import atw_pkg::*;
(
  input wire logic clock,
  input wire logic start,
  input wire logic [2:0] half,
  input wire logic [4:0] nbits,
  input wire logic [6:0] addr,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic [7:0] rdata,
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // ************************************************************
  // frame engine
  // ************************************************************
  // nbits below 16 gives an aborted frame on purpose
  task automatic frame();
    logic [15:0] sh;
    sh = {addr, wr, wdata};
    if (addr == ATW_ADDR_TEST) sh[8] = 1'b0;
    if (addr == ATW_ADDR_TRIM1) sh[5:4] = 2'b00;
    busy <= 1'b1;
    spi_ss_n <= 1'b0;
    for (int i = 15; i > 15 - int'(nbits); i--) begin
      spi_mosi <= sh[i];
      repeat (half) @(posedge clock);
      spi_sclk <= 1'b1;
      // one edge late, so the registered serial output has surely moved
      @(posedge clock);
      if (i < 8) rdata[i] <= spi_miso;
      repeat (half - 3'h1) @(posedge clock);
      spi_sclk <= 1'b0;
    end
    repeat (half) @(posedge clock);
    spi_ss_n <= 1'b1;
    // a released line must not keep showing its last bit
    spi_mosi <= ~spi_mosi;
    busy <= 1'b0;
  endtask

  // one process owns every output of the model
  initial begin
    busy = 1'b0;
    rdata = 8'h00;
    spi_sclk = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
    forever begin
      @(posedge clock);
      if (start) begin
        frame();
      end
    end
  end
endmodule // atw_spi_master

// File: verif/tb_analog_trim_and_watchdog_window.sv
// self-checking bench for the trim bank and the window watchdog
`timescale 1ns/1ps
module tb_analog_trim_and_watchdog_window
  import atw_pkg::*;
;
  // short base period stands for one range class of the die
  localparam logic [23:0] BASE = 24'h000040;
  logic clock, arst_n, spi_sclk, spi_ss_n, spi_mosi, spi_miso, start, wr, busy;
  logic sense_path_select, wd_enable, wd_clear, wd_window_open, wd_timeout;
  logic [1:0] wd_period_select, oc_delay, b12_lo, b34_lo;
  logic [3:0] cur_trim;
  logic [2:0] b34_hi, b12_hi, hs23, hs1, b12_app, b34_app, half;
  logic [4:0] nbits;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  logic [31:0] lfsr;
  int mismatches, num_checks, c;
  int m[3];

  atw_trim_top #(.WD_BASE_CYC(BASE)) atw_trim_top_i (.clock(clock), .arst_n(arst_n),
    .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .sense_path_select(sense_path_select), .wd_enable(wd_enable),
    .wd_period_select(wd_period_select), .wd_clear(wd_clear),
    .wd_window_open(wd_window_open), .wd_timeout(wd_timeout),
    .switched_supply_oc_delay(oc_delay), .current_reference_trim(cur_trim),
    .bridge12_recopy_trim_low_sense(b12_lo), .bridge34_recopy_trim_high_sense(b34_hi),
    .bridge12_recopy_trim_high_sense(b12_hi), .bridge34_recopy_trim_low_sense(b34_lo),
    .highside23_recopy_trim(hs23), .highside1_recopy_trim(hs1),
    .bridge12_recopy_applied(b12_app), .bridge34_recopy_applied(b34_app));
  atw_spi_master atw_spi_master_i (.clock(clock), .start(start), .half(half), .nbits(nbits),
    .addr(addr), .wr(wr), .wdata(wdata), .busy(busy), .rdata(rdata), .spi_sclk(spi_sclk),
    .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpn(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                      input logic [4:0] n);
    int t;
    @(posedge clock);
    {addr, wr, wdata, nbits, start} <= {a, w, d, n, 1'b1};
    @(posedge clock);
    start <= 1'b0;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (busy !== 1'b0 && t < 400);
    if (w && n == 5'h10 && a >= ATW_ADDR_TRIM1 && a <= ATW_ADDR_TRIM3) begin
      m[a - ATW_ADDR_TRIM1] = (a == ATW_ADDR_TRIM1) ? d & 8'hCF : d;
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00, 5'h10);
    cmp("register read", exp, rdata);
  endtask

  task automatic chk_all();
    logic [7:0] e1, e2, e3;
    e1 = 8'(m[0]);
    e2 = 8'(m[1]);
    e3 = 8'(m[2]);
    cmp("oc delay", e1[7:6], oc_delay);
    cmp("reference trim", e1[3:0], cur_trim);
    cmp("b12 low", e2[7:6], b12_lo);
    cmp("b34 high", e2[5:3], b34_hi);
    cmp("b12 high", e2[2:0], b12_hi);
    cmp("b34 low", e3[7:6], b34_lo);
    cmp("hs23", e3[5:3], hs23);
    cmp("hs1", e3[2:0], hs1);
    rd(ATW_ADDR_TRIM1, {e1[7:6], 6'h00});
    rd(ATW_ADDR_TRIM2, 8'h00);
    rd(ATW_ADDR_TRIM3, 8'h00);
    for (int s = 0; s < 2; s++) begin
      sense_path_select <= s[0];
      repeat (2) @(posedge clock);
      cmp("b12 applied", s[0] ? e2[2:0] : {1'b0, e2[7:6]}, b12_app);
      cmp("b34 applied", s[0] ? e2[5:3] : {1'b0, e3[7:6]}, b34_app);
    end
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    m = '{0, 0, 0};
  endtask

  task automatic restore();
    for (int r = 0; r < 3; r++) begin
      lfsr = nxt(lfsr);
      xfer(ATW_ADDR_TRIM1 + 7'(r), 1'b1, lfsr[7:0], 5'h10);
    end
  endtask

  task automatic count_to(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clock);
      if (wd_timeout === 1'b1) k++;
    end
  endtask

  // measures one whole period between two expiries
  task automatic wd_period(input logic [1:0] s);
    int t, w, p;
    p = int'(BASE) >> s;
    wd_enable <= 1'b0;
    @(posedge clock);
    wd_period_select <= s;
    wd_enable <= 1'b1;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (wd_timeout !== 1'b1 && t < 300);
    t = 0;
    w = 0;
    do begin
      @(posedge clock);
      t++;
      if (wd_window_open === 1'b1) w++;
    end while (wd_timeout !== 1'b1 && t < 300);
    cmpn("wd period", p, t);
    cmpn("wd open span", p / 2, w);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    $display("Error run time expected end seen none");
    stop_test();
  end

  initial begin
    {arst_n, start, sense_path_select, wd_enable, wd_clear, wd_period_select} = '0;
    {addr, wr, wdata} = '0;
    half = 3'h2;
    nbits = 5'h10;
    lfsr = 32'h7C3F7BF0;
    m = '{0, 0, 0};
    do_reset();
    chk_all();
    $display("reset values done");
    for (int k = 0; k <= 8; k++) begin
      lfsr = nxt(lfsr);
      half <= 3'h2 + 3'(k % 3);
      xfer(ATW_ADDR_TRIM1, 1'b1, {2'(k), lfsr[5:4], 4'(k)}, 5'h10);
      xfer(ATW_ADDR_TRIM2, 1'b1, {2'(k), 3'(k), 3'(k + 3)}, 5'h10);
      xfer(ATW_ADDR_TRIM3, 1'b1, {2'(k + 1), 3'(k + 5), 3'(k)}, 5'h10);
      chk_all();
    end
    $display("field codes done");
    xfer(ATW_ADDR_TRIM2, 1'b1, 8'hFF, 5'h0A);
    xfer(7'h20, 1'b1, 8'hFF, 5'h10);
    rd(7'h20, 8'h00);
    rd(ATW_ADDR_TEST, 8'h00);
    chk_all();
    $display("abort and unmapped done");
    do_reset();
    chk_all();
    restore();
    chk_all();
    $display("mid-run reset done");
    for (int s = 3; s >= 0; s--) begin
      wd_period(2'(s));
    end
    repeat (48) @(posedge clock);
    wd_clear <= 1'b1;
    @(posedge clock);
    wd_clear <= 1'b0;
    // short enough that the next clear still lands in the closed half
    count_to(24, c);
    cmpn("open clear timeouts", 0, c);
    repeat (2) @(posedge clock);
    wd_clear <= 1'b1;
    @(posedge clock);
    wd_clear <= 1'b0;
    count_to(3, c);
    cmpn("closed clear timeouts", 1, c);
    wd_enable <= 1'b0;
    wd_clear <= 1'b1;
    @(posedge clock);
    wd_clear <= 1'b0;
    count_to(3, c);
    cmpn("disabled clear timeouts", 0, c);
    $display("watchdog done");
    stop_test();
  end
endmodule // tb_analog_trim_and_watchdog_window
